// >>> hw/isr_consts.vh
`ifndef ISR_CONSTS_VH
`define ISR_CONSTS_VH
// Two-wire addressing
`define ISR_ADDR_MASTER_LO   7'h59
`define ISR_ADDR_MASTER_HI   7'h5a
`define ISR_ADDR_SLAVE_LO    7'h5b
`define ISR_ADDR_SLAVE_HI    7'h5c
`define ISR_ADDR_LISTEN_LO   7'h5d
`define ISR_ADDR_LISTEN_HI   7'h5e
`define ISR_ADDR_MUTE_LO     7'h61
`define ISR_ADDR_MUTE_HI     7'h62
`define ISR_ROLE_MASTER      2'h3
`define ISR_ROLE_SLAVE       2'h0
`define ISR_ROLE_LISTEN      2'h1
// Register offsets
`define ISR_OFS_SELECT       24'h020001
`define ISR_OFS_MUTE         24'h000000
// Select register fields
`define ISR_BIT_LEFT_FMT     4
`define ISR_BIT_HIGH_DIG     3
`define ISR_BIT_LOW_DIG      2
`define ISR_BIT_SPDIF        0
`define ISR_SEL_UPPER        16'hf800
`define ISR_SEL_MASK         8'h1d
// Route codes per channel pair
`define ISR_SRC_ANALOG       2'h0
`define ISR_SRC_SERIAL       2'h1
`define ISR_SRC_SPDIF        2'h2
`define ISR_SRC_NONE         2'h3
// Fixed gain structure, in dB
`define ISR_IN_ATTEN_DB      8'hfa
`define ISR_OUT_GAIN_DB      8'h12
`define ISR_CH_ATTEN_DB      8'hf4
// Byte counts and last bit index
`define ISR_BYTES_WRITE      3'h6
`define ISR_BIT_LAST         3'h7
`define ISR_BYTES_OFS        3'h3
// Enabled edges before the synchronised straps are loaded
`define ISR_STRAP_WAIT       2'h2
`endif

// >>> hw/isr_sync.v
`timescale 1ns/10ps
// Two flip-flop synchroniser for one pin
module isr_sync (
  input  wire clk,
  input  wire rst_n,
  input  wire clk_en,
  input  wire din,
  output reg  dout
);
  reg stage1;

  // ===========================================================
  // Synchroniser stages
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= 1'b1;
      dout   <= 1'b1;
    end else if (clk_en) begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // isr_sync

// >>> hw/isr_regs.v
`timescale 1ns/10ps
`include "isr_consts.vh"
// Overview of operation
// - Access uses device address plus 24-bit offset
// - Device address selects four-channel register set
// - Offset zero at mute addresses mutes all
// - Select register sits at offset 020001
// - Bit 4 picks left-justified or I2S
// - Bit 3 routes high pair serial/analog
// - Bit 2 routes low pair unless S/PDIF
// - Bit 0 connects S/PDIF to low pair
// - Reset loads route bits from strap pins
// - Group A channels 1-4, group B 5-8
// - Serial left to odd, right to even
// - Listen mode routing ignores the select register
// - Software selection not saved, straps restore
// - Other settings ramp smoothly, no pop
// - Other defaults load from EEPROM store
// - Fixed -6dB in, +18dB out, -12dB default
// - Two addresses chosen by role straps
module isr_regs (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       clk_en,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output wire       sda_oe_n,
  input  wire [1:0] module_role_straps,
  input  wire [3:0] digital_analog_strap,
  input  wire [1:0] low_pair_spdif_select,
  output reg  [7:0] pair_route,
  output reg        left_format_a,
  output reg        left_format_b,
  output reg        serial_left_odd,
  output reg        mute_all,
  output wire [7:0] input_atten_db,
  output wire [7:0] output_gain_db,
  output wire [7:0] channel_atten_default_db,
  output reg  [23:0] read_data_a,
  output reg  [23:0] read_data_b
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_ACK  = 3'h2;
  localparam ST_RECV = 3'h3;
  localparam ST_SEND = 3'h4;
  localparam ST_MACK = 3'h5;
  localparam ST_SKIP = 3'h6;

  wire       scl_s;
  wire       sda_s;
  reg        scl_d;
  reg        sda_d;
  reg [2:0]  state;
  reg [2:0]  bit_cnt;
  reg [2:0]  byte_cnt;
  reg [7:0]  shift;
  reg        is_read;
  reg        grp_b;
  reg [23:0] offset;
  reg [23:0] data_w;
  reg [23:0] rd_word;
  reg [7:0]  sel_a;
  reg [7:0]  sel_b;
  reg        strap_load;
  reg [1:0]  role;
  reg [1:0]  strap_cnt;
  wire [7:0] strap_pin;
  wire [7:0] strap_s;
  wire [1:0] role_s;
  wire [3:0] dig_s;
  wire [1:0] spdif_s;
  genvar     gi;
  // Edge and condition detect on the synchronised lines
  wire       scl_rise = scl_s & ~scl_d;
  wire       scl_fall = ~scl_s & scl_d;
  wire       start_c  = scl_s & scl_d & sda_d & ~sda_s;
  wire       stop_c   = scl_s & scl_d & ~sda_d & sda_s;
  wire [7:0] byte_in  = {shift[6:0], sda_s};
  reg        addr_hit;
  reg        addr_grp;

  // ===========================================================
  // Pin synchronisers
  isr_sync u_sync_scl (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .din(scl_in), .dout(scl_s));
  isr_sync u_sync_sda (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .din(sda_in), .dout(sda_s));

  // ===========================================================
  // Strap pins pass the same two stages before the load
  assign strap_pin = {module_role_straps, digital_analog_strap, low_pair_spdif_select};
  assign role_s    = strap_s[7:6];
  assign dig_s     = strap_s[5:2];
  assign spdif_s   = strap_s[1:0];
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_strap
      isr_sync u_sync_strap (
        .clk    (clk),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .din    (strap_pin[gi]),
        .dout   (strap_s[gi])
      );
    end
  endgenerate

  assign sda_oe_n = sda_out;
  assign input_atten_db = `ISR_IN_ATTEN_DB;
  assign output_gain_db = `ISR_OUT_GAIN_DB;
  assign channel_atten_default_db = `ISR_CH_ATTEN_DB;

  // ===========================================================
  // Address decode: two addresses per role plus mute pair
  always @* begin
    addr_hit = 1'b0;
    addr_grp = 1'b0;
    case (role)
      `ISR_ROLE_MASTER: begin
        addr_hit = (byte_in[7:1] == `ISR_ADDR_MASTER_LO) | (byte_in[7:1] == `ISR_ADDR_MASTER_HI);
        addr_grp = (byte_in[7:1] == `ISR_ADDR_MASTER_HI);
      end
      `ISR_ROLE_SLAVE: begin
        addr_hit = (byte_in[7:1] == `ISR_ADDR_SLAVE_LO) | (byte_in[7:1] == `ISR_ADDR_SLAVE_HI);
        addr_grp = (byte_in[7:1] == `ISR_ADDR_SLAVE_HI);
      end
      `ISR_ROLE_LISTEN: begin
        addr_hit = (byte_in[7:1] == `ISR_ADDR_LISTEN_LO) | (byte_in[7:1] == `ISR_ADDR_LISTEN_HI);
        addr_grp = (byte_in[7:1] == `ISR_ADDR_LISTEN_HI);
      end
      default: begin
        addr_hit = 1'b0;
        addr_grp = 1'b0;
      end
    endcase
    if ((byte_in[7:1] == `ISR_ADDR_MUTE_LO) | (byte_in[7:1] == `ISR_ADDR_MUTE_HI)) begin
      addr_hit = 1'b1;
      addr_grp = (byte_in[7:1] == `ISR_ADDR_MUTE_HI);
    end
  end

  // ===========================================================
  // Two-wire slave engine and register file
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_d      <= 1'b1;
      sda_d      <= 1'b1;
      state      <= ST_IDLE;
      bit_cnt    <= 3'h0;
      byte_cnt   <= 3'h0;
      shift      <= 8'h00;
      is_read    <= 1'b0;
      grp_b      <= 1'b0;
      offset     <= 24'h000000;
      data_w     <= 24'h000000;
      rd_word    <= 24'h000000;
      sel_a      <= 8'h00;
      sel_b      <= 8'h00;
      strap_load <= 1'b1;
      strap_cnt  <= 2'h0;
      role       <= 2'h0;
      sda_out    <= 1'b1;
      mute_all   <= 1'b0;
    end else if (clk_en) begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      // Straps captured once, after their synchronisers have filled
      if (strap_load && (strap_cnt != `ISR_STRAP_WAIT)) begin
        strap_cnt <= strap_cnt + 2'h1;
      end else if (strap_load) begin
        strap_load <= 1'b0;
        role       <= role_s;
        // Bit 4 starts as I2S, reserved bits stay zero
        sel_a <= {3'h0, 1'b0, dig_s[1], dig_s[0], 1'b0, spdif_s[0]};
        sel_b <= {3'h0, 1'b0, dig_s[3], dig_s[2], 1'b0, spdif_s[1]};
      end
      if (start_c) begin
        state   <= ST_ADDR;
        bit_cnt <= 3'h0;
        sda_out <= 1'b1;
      end else if (stop_c) begin
        state   <= ST_IDLE;
        sda_out <= 1'b1;
      end else begin
        case (state)
          ST_ADDR, ST_RECV: begin
            // Bits are taken on the synchronised SCL rise
            if (scl_rise) begin
              shift   <= byte_in;
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == `ISR_BIT_LAST) begin
                if (state == ST_ADDR) begin
                  state <= addr_hit ? ST_ACK : ST_SKIP;
                  is_read <= byte_in[0];
                  grp_b <= addr_grp;
                  byte_cnt <= 3'h0;
                  rd_word <= addr_grp ? {`ISR_SEL_UPPER, sel_b} : {`ISR_SEL_UPPER, sel_a};
                end else begin
                  state <= ST_ACK;
                  if (byte_cnt < `ISR_BYTES_OFS)
                    offset <= {offset[15:0], byte_in};
                  else
                    data_w <= {data_w[15:0], byte_in};
                  byte_cnt <= byte_cnt + 3'h1;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_fall && sda_out) begin
              sda_out <= 1'b0;
            end else if (scl_fall && !sda_out) begin
              sda_out <= 1'b1;
              bit_cnt <= 3'h0;
              if (is_read) begin
                state   <= ST_SEND;
                sda_out <= rd_word[23];
                rd_word <= {rd_word[22:0], 1'b0};
              end else if (byte_cnt == `ISR_BYTES_WRITE) begin
                state <= ST_SKIP;
                // Commit only after the last data byte is acknowledged
                if (offset == `ISR_OFS_SELECT) begin
                  if (grp_b)
                    sel_b <= data_w[7:0] & `ISR_SEL_MASK;
                  else
                    sel_a <= data_w[7:0] & `ISR_SEL_MASK;
                end
                if (offset == `ISR_OFS_MUTE)
                  mute_all <= |data_w;
              end else begin
                state <= ST_RECV;
              end
            end
          end
          ST_SEND: begin
            // Read bits change only while SCL is low
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == `ISR_BIT_LAST) begin
                state   <= ST_MACK;
                sda_out <= 1'b1;
              end else begin
                sda_out <= rd_word[23];
                rd_word <= {rd_word[22:0], 1'b0};
              end
            end
          end
          ST_MACK: begin
            // Not acknowledged: stop sending; acknowledged: next byte on the fall
            if (scl_rise && sda_s) begin
              state <= ST_SKIP;
            end else if (scl_fall) begin
              state   <= ST_SEND;
              bit_cnt <= 3'h0;
              sda_out <= rd_word[23];
              rd_word <= {rd_word[22:0], 1'b0};
            end
          end
          ST_SKIP: begin
            // Ignored until the next START or STOP
            sda_out <= 1'b1;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ===========================================================
  // Readback and route outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      read_data_a     <= 24'h000000;
      read_data_b     <= 24'h000000;
      pair_route      <= {4{`ISR_SRC_NONE}};
      left_format_a   <= 1'b0;
      left_format_b   <= 1'b0;
      serial_left_odd <= 1'b1;
    end else if (clk_en) begin
      read_data_a     <= {`ISR_SEL_UPPER, sel_a};
      read_data_b     <= {`ISR_SEL_UPPER, sel_b};
      left_format_a   <= sel_a[`ISR_BIT_LEFT_FMT];
      left_format_b   <= sel_b[`ISR_BIT_LEFT_FMT];
      serial_left_odd <= 1'b1;
      // Listen role leaves routing to the module link
      if (role == `ISR_ROLE_LISTEN) begin
        pair_route <= {4{`ISR_SRC_NONE}};
      end else begin
        pair_route[1:0] <= sel_a[`ISR_BIT_SPDIF] ? `ISR_SRC_SPDIF :
                           (sel_a[`ISR_BIT_LOW_DIG] ? `ISR_SRC_SERIAL : `ISR_SRC_ANALOG);
        pair_route[3:2] <= sel_a[`ISR_BIT_HIGH_DIG] ? `ISR_SRC_SERIAL : `ISR_SRC_ANALOG;
        pair_route[5:4] <= sel_b[`ISR_BIT_SPDIF] ? `ISR_SRC_SPDIF :
                           (sel_b[`ISR_BIT_LOW_DIG] ? `ISR_SRC_SERIAL : `ISR_SRC_ANALOG);
        pair_route[7:6] <= sel_b[`ISR_BIT_HIGH_DIG] ? `ISR_SRC_SERIAL : `ISR_SRC_ANALOG;
      end
    end
  end
endmodule // isr_regs

// >>> tb/isr_chk_checker.sv
`timescale 1ns/10ps
// ==========================================
// Port checker for the input select registers
module isr_chk (
  input wire        clk,
  input wire        rst_n,
  input wire        scl_in,
  input wire        sda_in,
  input wire [1:0]  module_role_straps,
  input wire [3:0]  digital_analog_strap,
  input wire [1:0]  low_pair_spdif_select,
  input wire [7:0]  pair_route,
  input wire        left_format_a,
  input wire        left_format_b,
  input wire        serial_left_odd,
  input wire        mute_all,
  input wire [7:0]  input_atten_db,
  input wire [7:0]  output_gain_db,
  input wire [7:0]  channel_atten_default_db,
  input wire [23:0] read_data_a,
  input wire [23:0] read_data_b
);
  reg [2:0] up;
  reg [3:0] idle;
  wire      own;
  wire      stab;
  // Cycles since reset release, cycles of an idle bus
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up   <= 3'h0;
      idle <= 4'h0;
    end else begin
      up   <= (up == 3'h7) ? up : up + 3'h1;
      idle <= !(scl_in && sda_in) ? 4'h0 : (idle == 4'hf) ? idle : idle + 4'h1;
    end
  end
  // Routing owned by the register; expected low pair code
  assign own = (up == 3'h7) && (module_role_straps != 2'h1);
  function [1:0] lo(input [23:0] s);
    lo = s[0] ? 2'h2 : {1'b0, s[2]};
  endfunction
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================
  // Assertions
  gain_consts_a: assert property (input_atten_db == 8'hfa && output_gain_db == 8'h12)
    else $error("fixed gains wrong");
  atten_dflt_a: assert property (channel_atten_default_db == 8'hf4)
    else $error("channel attenuation default wrong");
  left_odd_a: assert property (up > 3'h2 |-> serial_left_odd)
    else $error("left sample not on odd channel");
  strap_load_a: assert property ((up == 3'h4 && module_role_straps != 2'h1) |-> pair_route[3:0] ==
    {1'b0, digital_analog_strap[1], low_pair_spdif_select[0] ? 2'h2 : {1'b0, digital_analog_strap[0]}})
    else $error("strap defaults not loaded");
  low_route_a: assert property ((own && $stable(read_data_a))[*4] |-> pair_route[1:0] == lo(read_data_a))
    else $error("low pair route wrong");
  high_route_a: assert property ((own && $stable(read_data_a))[*4] |-> pair_route[3:2] == {1'b0, read_data_a[3]})
    else $error("high pair route wrong");
  group_b_a: assert property ((own && $stable(read_data_b))[*4] |->
    pair_route[7:4] == {1'b0, read_data_b[3], lo(read_data_b)}) else $error("group b route wrong");
  fmt_bit_a: assert property ((up == 3'h7 && $stable(read_data_a) && $stable(read_data_b))[*4] |->
    left_format_a == read_data_a[4] && left_format_b == read_data_b[4]) else $error("format bit wrong");
  listen_none_a: assert property ((up == 3'h7 && module_role_straps == 2'h1) |-> pair_route == 8'hff)
    else $error("listen role routes");
  idle_hold_a: assert property (idle > 4'hb |-> $stable(mute_all) && $stable(read_data_a) && $stable(read_data_b))
    else $error("state moved on idle bus");
  sel_upper_a: assert property (up == 3'h7 |-> read_data_a[23:8] == 16'hf800 && read_data_b[23:8] == 16'hf800)
    else $error("select upper bits wrong");
  // Main scenarios
  mute_c: cover property ($rose(mute_all));
  listen_c: cover property (pair_route == 8'hff && up == 3'h7);
  fmt_c: cover property (left_format_a && left_format_b);
endmodule // isr_chk

// >>> tb/isr_host.sv
`timescale 1ns/10ps
// ==========================================
// Two-wire bus master model, SCL period 160 ns
module isr_host (
  input  wire clk,
  input  wire sda_line,
  output reg  scl,
  output reg  sda_drv
);
  // Idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task q;
    begin
      repeat (2) @(posedge clk);
      #2;
    end
  endtask
  // Start or repeated start, and stop
  task start;
    begin
      q; sda_drv = 1'b1; q; scl = 1'b1; q; sda_drv = 1'b0; q; scl = 1'b0;
    end
  endtask
  task stop;
    begin
      q; sda_drv = 1'b0; q; scl = 1'b1; q; sda_drv = 1'b1; q;
    end
  endtask
  // One bit: data set while SCL low, read at the end of SCL high
  task bit_x(input b, output r);
    begin
      q; sda_drv = b; q; scl = 1'b1; q; q; r = sda_line; scl = 1'b0;
    end
  endtask
  task byte_x(input [7:0] x, input mack, output [7:0] r, output ack);
    integer i;
    reg     b;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bit_x(x[i], b);
        r = {r[6:0], b};
      end
      bit_x(mack, ack);
    end
  endtask
  // Send a byte, count the acknowledges
  task tx(input [7:0] x, inout integer na);
    reg [7:0] r;
    reg       k;
    begin
      byte_x(x, 1'b1, r, k);
      na = na + (k ? 0 : 1);
    end
  endtask
  // Address, three offset bytes, three data bytes, MSB first
  task wr(input [6:0] a, input [23:0] o, input [23:0] d, output integer na);
    begin
      na = 0;
      start; tx({a, 1'b0}, na); tx(o[23:16], na); tx(o[15:8], na); tx(o[7:0], na);
      tx(d[23:16], na); tx(d[15:8], na); tx(d[7:0], na); stop;
    end
  endtask
  // Offset phase, repeated start, three data bytes, last one not acknowledged
  task rd(input [6:0] a, input [23:0] o, output [23:0] d, output integer na);
    reg [7:0] r;
    reg       k;
    integer   j;
    begin
      na = 0;
      start; tx({a, 1'b0}, na); tx(o[23:16], na); tx(o[15:8], na); tx(o[7:0], na);
      start; tx({a, 1'b1}, na);
      for (j = 2; j >= 0; j = j - 1) begin
        byte_x(8'hff, j == 0, r, k);
        d = {d[15:0], r};
      end
      stop;
    end
  endtask
endmodule // isr_host

// >>> tb/testbench.sv
`timescale 1ns/10ps
// ==========================================
// Self-checking bench for the input select registers
module testbench;
  localparam [31:0] VALS = 32'h1d04_0800;
  reg         clk;
  reg         rst_n;
  reg  [1:0]  role;
  reg  [3:0]  dig;
  reg  [1:0]  spd;
  integer     fails;
  integer     n_checks;
  integer     na;
  integer     i;
  reg  [23:0] d;
  reg  [7:0]  v;
  wire        scl;
  wire        sda_drv;
  wire        sda_out;
  wire        sda_oe_n;
  wire        sda;
  wire [7:0]  route;
  wire        fmt_a;
  wire        fmt_b;
  wire        mute;
  wire [23:0] rd_a;
  wire [23:0] rd_b;
  // Open-drain data line with pull-up
  assign sda = sda_drv & (sda_oe_n | sda_out);
  isr_regs dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .module_role_straps(role), .digital_analog_strap(dig), .low_pair_spdif_select(spd),
    .pair_route(route), .left_format_a(fmt_a), .left_format_b(fmt_b), .serial_left_odd(), .mute_all(mute),
    .input_atten_db(), .output_gain_db(), .channel_atten_default_db(), .read_data_a(rd_a), .read_data_b(rd_b));
  isr_host hm (.clk(clk), .sda_line(sda), .scl(scl), .sda_drv(sda_drv));
  // 50 MHz clock
  initial clk = 1'b0;
  always #10 clk = ~clk;
  task chk(input string nm, input [23:0] e, input [23:0] g);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("BAD %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Expected route nibble of one group from its select byte
  function [3:0] nib(input [7:0] s);
    nib = {1'b0, s[3], s[0] ? 2'h2 : {1'b0, s[2]}};
  endfunction
  // Reset for three cycles with straps held
  task do_reset(input [1:0] r, input [3:0] g, input [1:0] s);
    begin
      rst_n = 1'b0; role = r; dig = g; spd = s;
      repeat (3) @(posedge clk);
      #2 rst_n = 1'b1;
      repeat (8) @(posedge clk);
      #2;
    end
  endtask
  // ==========================================
  // Scenarios
  task t_straps;
    begin
      do_reset(2'h3, 4'h3, 2'h2);
      chk("route", 24'h25, {16'h0, route});
      chk("sel_a", 24'hf8000c, rd_a);
      chk("sel_b", 24'hf80001, rd_b);
      chk("fmt", 24'h0, {22'h0, fmt_b, fmt_a});
    end
  endtask
  task t_select;
    begin
      hm.wr(7'h61, 24'h0, 24'h1, na); hm.wr(7'h62, 24'h0, 24'h1, na);
      chk("mute", 24'h1, {23'h0, mute});
      for (i = 0; i < 4; i = i + 1) begin
        v = VALS[24 - i * 8 +: 8];
        hm.wr(7'h59, 24'h020001, {16'hf800, v}, na);
        hm.wr(7'h5a, 24'h020001, {16'hf800, v ^ 8'h1d}, na);
        chk("acks", 24'h7, na[23:0]);
        chk("route_a", {20'h0, nib(v)}, {20'h0, route[3:0]});
        chk("route_b", {20'h0, nib(v ^ 8'h1d)}, {20'h0, route[7:4]});
        chk("fmt", {22'h0, ~v[4], v[4]}, {22'h0, fmt_b, fmt_a});
        hm.rd(7'h59, 24'h020001, d, na);
        chk("read_a", {16'hf800, v}, d);
      end
      hm.wr(7'h61, 24'h0, 24'h0, na); hm.wr(7'h62, 24'h0, 24'h0, na);
      chk("unmute", 24'h0, {23'h0, mute});
    end
  endtask
  task t_refuse;
    begin
      hm.wr(7'h5b, 24'h020001, 24'hf8001d, na);
      chk("acks", 24'h0, na[23:0]);
      hm.wr(7'h59, 24'h020002, 24'hf8001d, na);
      chk("route", 24'h60, {16'h0, route});
    end
  endtask
  task t_listen;
    begin
      do_reset(2'h3, 4'h3, 2'h2);
      chk("route", 24'h25, {16'h0, route});
      do_reset(2'h1, 4'hc, 2'h1);
      hm.wr(7'h5d, 24'h020001, 24'hf80008, na);
      chk("route", 24'hff, {16'h0, route});
      do_reset(2'h0, 4'h0, 2'h0);
      hm.wr(7'h5c, 24'h020001, 24'hf80004, na);
      chk("acks", 24'h7, na[23:0]);
      chk("route", 24'h10, {16'h0, route});
    end
  endtask
  // Main sequence
  initial begin
    fails = 0;
    n_checks = 0;
    t_straps;
    t_select;
    t_refuse;
    t_listen;
    results;
  end
  // Watchdog
  initial begin
    #1000000;
    fails = fails + 1;
    results;
  end
endmodule // testbench
bind isr_regs isr_chk chk (.clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
  .module_role_straps(module_role_straps), .digital_analog_strap(digital_analog_strap),
  .low_pair_spdif_select(low_pair_spdif_select), .pair_route(pair_route), .left_format_a(left_format_a),
  .left_format_b(left_format_b), .serial_left_odd(serial_left_odd), .mute_all(mute_all),
  .input_atten_db(input_atten_db), .output_gain_db(output_gain_db),
  .channel_atten_default_db(channel_atten_default_db), .read_data_a(read_data_a), .read_data_b(read_data_b));
